// ===== hw/pops_ctrl.sv
// pops_ctrl: on/off policy, fault clear, write lock and store/restore
// for an eight channel supply manager, driven by a decoded command port.
// assumes a protocol engine upstream turns bus writes/reads into one-cycle
// cmd_valid pulses and waits for cmd_ack or cmd_nack before the next.
// Notes on behaviour
// - global page writes config to masked channels
// - no sequencing until input above turn-on
// - wait init time; readback valid later
// - config bits 7:5 read zero, bit1 one
// - autonomous mode powers up with delay
// - controlled mode needs pin/command; 00 never
// - use-command bit gates operation control field
// - use-pin bit gates channel run pin
// - pin off: delay, or fast immediate off
// - clear faults: unpaged plus selected page
// - clear faults releases alert line; here only once no sticky fault bit of any page or input stays set
// - clear faults never restarts latched channel
// - persisting fault sets its bit again
// - clear faults not global on all-pages
// - reads allowed at every lock level
// - level one: only lock, page, store
// - level two adds operation, mask, clear
// - zero unlocks all; other codes reserved
// - restore on command and at power-on
// - writes refused while transfer runs
// - store copies image, monitoring suspended
// - restore reloads image, monitoring suspended
// - channel on/off from command and pin
`timescale 1ns/100ps
module pops_ctrl
   import pops_pkg::*;
#(
   parameter int          INIT_CYCLES = pops_pkg::INIT_CYC,
   parameter int          RB_CYCLES   = pops_pkg::READBACK_CYC,
   parameter logic [15:0] TON_TICKS   = 16'h0064,
   parameter logic [15:0] TOFF_TICKS  = 16'h0064
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   cmd_valid,
   input  wire logic                   cmd_write,
   input  wire logic [7:0]             cmd_code,
   input  wire logic [7:0]             cmd_wdata,
   output logic                        cmd_ack,
   output logic                        cmd_nack,
   output logic      [7:0]             cmd_rdata,
   input  wire logic [pops_pkg::N_CH-1:0] channel_run_pin,
   input  wire logic                   input_voltage_sense,
   input  wire logic [pops_pkg::N_CH-1:0] chan_fault,
   input  wire logic                   vin_fault,
   input  wire logic [pops_pkg::N_CH-1:0] chan_latched_off,
   output logic      [pops_pkg::N_CH-1:0] channel_supply_enable_out,
   output logic                        shared_alert_output_o,
   output logic                        shared_alert_output_oe,
   output logic                        monitor_suspend,
   output logic                        init_done,
   output logic                        readback_valid
);
   typedef struct packed {
      logic [N_CH-1:0][7:0]  cfg;
      logic [N_CH-1:0][1:0]  opc;
      logic [7:0]            page;
      logic [7:0]            mask;
      logic [7:0]            wl;
      logic [N_CH-1:0]       pflt;
      logic                  uflt;
      logic                  alert;
      pops_ch_t [N_CH-1:0]   chs;
      logic [N_CH-1:0][15:0] cnt;
      logic [N_CH-1:0]       en;
      pops_xf_t              xs;
      logic [NV_AW:0]        idx;
      logic                  suspend;
      logic [22:0]           tmr;
      logic                  init_done;
      logic                  rb_valid;
      logic [7:0]            div;
      logic                  tick;
      logic                  ack;
      logic                  nack;
      logic [7:0]            rdata;
   } pops_state_t;

   pops_state_t s_r;
   pops_state_t s_nxt;
   logic [N_CH-1:0] pin_s;
   logic            vin_ok;
   logic [7:0]      mem_rd;
   logic            mem_we;
   logic [NV_AW-1:0] mem_addr;
   logic [7:0]      mem_wd;

   initial begin
      if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << 23)) $error("pops_ctrl: INIT_CYCLES range");
      if (RB_CYCLES < 1 || RB_CYCLES >= (1 << 23)) $error("pops_ctrl: RB_CYCLES range");
      if (TICK_CYC > 255) $error("pops_ctrl: tick divider too narrow");
   end

   pops_sync #(.W(N_CH + 1)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .din     ({input_voltage_sense, channel_run_pin}),
      .dout    ({vin_ok, pin_s})
   );

   pops_store_mem #(.DEPTH(16)) u_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wd),
      .rdata   (mem_rd)
   );

   // writes honoured at a given lock level
   function automatic logic wr_ok(input logic [7:0] wl, input logic [7:0] code);
      logic base;
      logic lvl2;
      base = (code == CMD_WRITE_LOCK) || (code == CMD_PAGE) || (code == CMD_STORE_ALL);
      lvl2 = (code == CMD_OPERATION) || (code == CMD_CH_MASK) || (code == CMD_CLEAR_FAULTS);
      if (wl == WL_NONE) return 1'b1;
      if (wl == WL_L2) return base || lvl2;
      return base;
   endfunction

   // channels addressed by a paged write
   function automatic logic [N_CH-1:0] targets(input logic [7:0] page, input logic [7:0] mask);
      logic [N_CH-1:0] t;
      t = '0;
      if (page == PAGE_ALL) t = mask[N_CH-1:0];
      else if (page < 8'(N_CH)) t[page[2:0]] = 1'b1;
      return t;
   endfunction

   function automatic logic [7:0] cfg_clean(input logic [7:0] v);
      return (v & CFG_WR_MASK) | CFG_FORCE1;
   endfunction

   function automatic logic known(input logic [7:0] c);
      return c == CMD_PAGE || c == CMD_OPERATION || c == CMD_ON_OFF
          || c == CMD_CLEAR_FAULTS || c == CMD_WRITE_LOCK || c == CMD_STORE_ALL
          || c == CMD_RESTORE_ALL || c == CMD_STATUS_CH || c == CMD_STATUS_IN
          || c == CMD_CH_MASK;
   endfunction

   // image word for a given index
   always_comb begin
      mem_addr = s_r.idx[NV_AW-1:0];
      mem_we   = (s_r.xs == XF_STORE) && (s_r.idx < (NV_AW+1)'(NV_WORDS));
      if (mem_addr == NV_WL_IDX) mem_wd = s_r.wl;
      else if (mem_addr == NV_MASK_IDX) mem_wd = s_r.mask;
      else mem_wd = s_r.cfg[mem_addr[2:0]];
   end

   always_comb begin
      logic [N_CH-1:0] tg;
      logic [7:0]      c;
      logic [NV_AW-1:0] prev;
      logic            req;
      logic            quick;
      logic            go;
      logic            clr;
      tg    = targets(s_r.page, s_r.mask);
      c     = 8'h00;
      prev  = '0;
      req   = 1'b0;
      quick = 1'b0;
      go    = 1'b0;
      clr   = 1'b0;
      s_nxt = s_r;
      s_nxt.ack  = 1'b0;
      s_nxt.nack = 1'b0;

      s_nxt.tick = (s_r.div == 8'(TICK_CYC - 1));
      s_nxt.div  = s_nxt.tick ? 8'h00 : s_r.div + 8'h01;

      if (cmd_valid && cmd_write) begin
         if (s_r.xs != XF_IDLE || !known(cmd_code)) s_nxt.nack = 1'b1;
         else if (!wr_ok(s_r.wl, cmd_code)) s_nxt.nack = 1'b1;
         else begin
            s_nxt.ack = 1'b1;
            unique case (cmd_code)
               CMD_PAGE: s_nxt.page = cmd_wdata;
               CMD_CH_MASK: s_nxt.mask = cmd_wdata;
               CMD_OPERATION, CMD_ON_OFF: begin
                  if (tg == '0) begin
                     s_nxt.ack  = 1'b0;
                     s_nxt.nack = 1'b1;
                  end
                  for (int i = 0; i < N_CH; i++) begin
                     if (tg[i] && cmd_code == CMD_ON_OFF) s_nxt.cfg[i] = cfg_clean(cmd_wdata);
                     if (tg[i] && cmd_code == CMD_OPERATION)
                        s_nxt.opc[i] = cmd_wdata[OP_CTL_LO+1:OP_CTL_LO];
                  end
               end
               CMD_CLEAR_FAULTS: clr = 1'b1;
               CMD_WRITE_LOCK: begin
                  if (cmd_wdata == WL_NONE || cmd_wdata == WL_L1 || cmd_wdata == WL_L2)
                     s_nxt.wl = cmd_wdata;
                  else begin
                     s_nxt.ack  = 1'b0;
                     s_nxt.nack = 1'b1;
                  end
               end
               CMD_STORE_ALL: begin
                  s_nxt.xs  = XF_STORE;
                  s_nxt.idx = '0;
               end
               CMD_RESTORE_ALL: begin
                  s_nxt.xs  = XF_RESTORE;
                  s_nxt.idx = '0;
               end
               default: begin
                  s_nxt.ack  = 1'b0;
                  s_nxt.nack = 1'b1;
               end
            endcase
         end
      end else if (cmd_valid) begin
         s_nxt.ack   = known(cmd_code);
         s_nxt.nack  = !known(cmd_code);
         s_nxt.rdata = 8'h00;
         if (cmd_code == CMD_PAGE) s_nxt.rdata = s_r.page;
         if (cmd_code == CMD_CH_MASK) s_nxt.rdata = s_r.mask;
         if (cmd_code == CMD_WRITE_LOCK) s_nxt.rdata = s_r.wl;
         if (cmd_code == CMD_STATUS_IN) s_nxt.rdata[STS_VIN_B] = s_r.uflt;
         if (s_r.page < 8'(N_CH)) begin
            if (cmd_code == CMD_ON_OFF) s_nxt.rdata = cfg_clean(s_r.cfg[s_r.page[2:0]]);
            if (cmd_code == CMD_OPERATION)
               s_nxt.rdata[OP_CTL_LO+1:OP_CTL_LO] = s_r.opc[s_r.page[2:0]];
            if (cmd_code == CMD_STATUS_CH) s_nxt.rdata[STS_CH_FLT_B] = s_r.pflt[s_r.page[2:0]];
         end
      end

      // clear unpaged and selected page only
      if (clr) begin
         s_nxt.uflt = 1'b0;
         if (s_r.page < 8'(N_CH)) s_nxt.pflt[s_r.page[2:0]] = 1'b0;
      end
      // live faults set again, winning over the clear
      s_nxt.pflt = s_nxt.pflt | chan_fault;
      s_nxt.uflt = s_nxt.uflt | vin_fault;
      // alert follows sticky status of all pages, so a clear releases it only when no bit stays set
      s_nxt.alert = (|s_nxt.pflt) | s_nxt.uflt;

      // image transfer, one word a cycle
      prev = s_r.idx[NV_AW-1:0] - 1'b1;
      if (s_r.xs == XF_STORE) begin
         s_nxt.idx = s_r.idx + 1'b1;
         if (s_r.idx == (NV_AW+1)'(NV_WORDS - 1)) s_nxt.xs = XF_IDLE;
      end else if (s_r.xs == XF_RESTORE) begin
         s_nxt.idx = s_r.idx + 1'b1;
         if (s_r.idx != '0) begin
            if (prev == NV_WL_IDX) s_nxt.wl = mem_rd;
            else if (prev == NV_MASK_IDX) s_nxt.mask = mem_rd;
            else s_nxt.cfg[prev[2:0]] = cfg_clean(mem_rd);
         end
         if (s_r.idx == (NV_AW+1)'(NV_WORDS)) s_nxt.xs = XF_IDLE;
      end
      s_nxt.suspend = (s_nxt.xs != XF_IDLE);

      // init delay after power-on restore, then readback delay
      if (s_r.xs == XF_IDLE && !s_r.rb_valid) begin
         s_nxt.tmr = s_r.tmr + 23'h1;
         if (!s_r.init_done && s_r.tmr == 23'(INIT_CYCLES - 1)) begin
            s_nxt.init_done = 1'b1;
            s_nxt.tmr       = '0;
         end
         if (s_r.init_done && s_r.tmr == 23'(RB_CYCLES - 1)) s_nxt.rb_valid = 1'b1;
      end

      for (int i = 0; i < N_CH; i++) begin
         c = s_r.cfg[i];
         if (!c[CFG_AUTO_B]) req = 1'b1;
         else if (!c[CFG_PMBUS_B] && !c[CFG_PIN_B]) req = 1'b0;
         else req = (!c[CFG_PMBUS_B] || s_r.opc[i] == OP_CTL_ON) && (!c[CFG_PIN_B] || pin_s[i]);
         // fast off from pin; command off is immediate
         quick = (c[CFG_AUTO_B] && c[CFG_PIN_B] && !pin_s[i] && c[CFG_FAST_B])
              || (c[CFG_AUTO_B] && c[CFG_PMBUS_B] && s_r.opc[i] == OP_CTL_OFF);
         // start needs init, input level, no latch-off
         go = req && s_r.init_done && vin_ok && !chan_latched_off[i];
         unique case (s_r.chs[i])
            CH_OFF: begin
               if (go && TON_TICKS == 16'h0000) begin
                  s_nxt.chs[i] = CH_ON;
                  s_nxt.en[i]  = 1'b1;
               end else if (go) begin
                  s_nxt.chs[i] = CH_WAIT_ON;
                  s_nxt.cnt[i] = TON_TICKS;
               end
            end
            CH_WAIT_ON: begin
               if (!go) s_nxt.chs[i] = CH_OFF;
               else if (s_r.tick && s_r.cnt[i] == 16'h0001) begin
                  s_nxt.chs[i] = CH_ON;
                  s_nxt.en[i]  = 1'b1;
               end else if (s_r.tick) s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
            end
            CH_ON, CH_WAIT_OFF: begin
               if (chan_latched_off[i] || quick || (!req && TOFF_TICKS == 16'h0000)
                   || (s_r.chs[i] == CH_WAIT_OFF && !req && s_r.tick
                       && s_r.cnt[i] == 16'h0001)) begin
                  s_nxt.chs[i] = CH_OFF;
                  s_nxt.en[i]  = 1'b0;
               end else if (req) s_nxt.chs[i] = CH_ON;
               else if (s_r.chs[i] == CH_ON) begin
                  s_nxt.chs[i] = CH_WAIT_OFF;
                  s_nxt.cnt[i] = TOFF_TICKS;
               end else if (s_r.tick) s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
            end
         endcase
      end
   end

   // power-on restore, image loads before init counts
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_r         <= '0;
         s_r.cfg     <= {N_CH{DEF_CFG}};
         s_r.opc     <= {N_CH{DEF_OPC}};
         s_r.mask    <= DEF_MASK;
         s_r.wl      <= DEF_WL;
         s_r.xs      <= XF_RESTORE;
         s_r.suspend <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cmd_ack                   = s_r.ack;
   assign cmd_nack                  = s_r.nack;
   assign cmd_rdata                 = s_r.rdata;
   assign channel_supply_enable_out = s_r.en;
   assign shared_alert_output_o     = 1'b0;
   assign shared_alert_output_oe    = s_r.alert;
   assign monitor_suspend           = s_r.suspend;
   assign init_done                 = s_r.init_done;
   assign readback_valid            = s_r.rb_valid;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_cfg_readback: assert property (cmd_valid && !cmd_write && cmd_code == CMD_ON_OFF
      && s_r.page < 8'(N_CH) |=> cmd_ack && cmd_rdata[7:5] == 3'h0 && cmd_rdata[1])
      else $error("config readback reserved bits wrong");
   a_busy_nack: assert property (cmd_valid && cmd_write && s_r.xs != XF_IDLE
      |=> cmd_nack && !cmd_ack)
      else $error("write accepted during transfer");
   a_lock_one: assert property (cmd_valid && cmd_write && s_r.wl == WL_L1
      && cmd_code == CMD_OPERATION |=> cmd_nack && $stable(s_r.opc))
      else $error("level one lock let operation through");
   a_lock_two: assert property (cmd_valid && cmd_write && s_r.wl == WL_L2 && s_r.xs == XF_IDLE
      && cmd_code == CMD_CLEAR_FAULTS |=> cmd_ack)
      else $error("level two lock refused clear faults");
   a_read_free: assert property (cmd_valid && !cmd_write && cmd_code == CMD_WRITE_LOCK
      |=> cmd_ack && cmd_rdata == $past(s_r.wl))
      else $error("read refused or wrong");
   a_alert_release: assert property (cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS
      && s_r.xs == XF_IDLE && s_r.wl != WL_L1 && s_r.page == 8'h00 && s_r.pflt[N_CH-1:1] == '0
      && chan_fault == '0 && !vin_fault |=> !shared_alert_output_oe)
      else $error("alert not released by clear");
   a_fault_resets: assert property (chan_fault[0] |=> s_r.pflt[0] && shared_alert_output_oe)
      else $error("live fault not set again");
   a_init_gate: assert property (!s_r.init_done |-> channel_supply_enable_out == '0)
      else $error("channel enabled before init");
   a_never_on: assert property (s_r.cfg[0][CFG_AUTO_B] && !s_r.cfg[0][CFG_PMBUS_B]
      && !s_r.cfg[0][CFG_PIN_B] && s_r.chs[0] == CH_OFF |=> !channel_supply_enable_out[0])
      else $error("channel started with no source");
   a_fast_off: assert property (s_r.chs[0] == CH_ON && s_r.cfg[0][CFG_AUTO_B]
      && s_r.cfg[0][CFG_PIN_B] && s_r.cfg[0][CFG_FAST_B] && !pin_s[0]
      |=> !channel_supply_enable_out[0])
      else $error("fast off not immediate");
   a_latch_hold: assert property (chan_latched_off[0] |=> !channel_supply_enable_out[0])
      else $error("latched channel enabled");
   a_vin_start: assert property ($rose(channel_supply_enable_out[0])
      |-> $past(vin_ok) || $past(s_r.chs[0]) != CH_OFF)
      else $error("start without input level");
   a_suspend_store: assert property (cmd_valid && cmd_write && cmd_code == CMD_STORE_ALL
      && cmd_ack == 1'b0 && s_r.xs == XF_IDLE |=> ##1 monitor_suspend [*8])
      else $error("monitoring not suspended during store");
endmodule

// ===== hw/pops_pkg.sv
// pops_pkg: command codes, field positions, reset values and timing for
// the on/off, protection and store control block.
// assumes a 25 MHz system clock and eight managed channels.
package pops_pkg;
   localparam int N_CH = 8;

   // command codes seen on the decoded command port
   localparam logic [7:0] CMD_PAGE         = 8'h00;
   localparam logic [7:0] CMD_OPERATION    = 8'h01;
   localparam logic [7:0] CMD_ON_OFF       = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_WRITE_LOCK   = 8'h10;
   localparam logic [7:0] CMD_STORE_ALL    = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL  = 8'h16;
   localparam logic [7:0] CMD_STATUS_CH    = 8'h78;
   localparam logic [7:0] CMD_STATUS_IN    = 8'h7c;
   localparam logic [7:0] CMD_CH_MASK      = 8'hd0;
   localparam logic [7:0] PAGE_ALL         = 8'hff;

   // power_on_policy_config fields
   localparam int         CFG_AUTO_B  = 4;
   localparam int         CFG_PMBUS_B = 3;
   localparam int         CFG_PIN_B   = 2;
   localparam int         CFG_FAST_B  = 0;
   localparam logic [7:0] CFG_WR_MASK = 8'h1d;
   localparam logic [7:0] CFG_FORCE1  = 8'h02;

   // operation control field
   localparam int         OP_CTL_LO  = 6;
   localparam logic [1:0] OP_CTL_OFF = 2'h0;
   localparam logic [1:0] OP_CTL_ON  = 2'h2;

   // write_lock_level codes
   localparam logic [7:0] WL_NONE = 8'h00;
   localparam logic [7:0] WL_L1   = 8'h80;
   localparam logic [7:0] WL_L2   = 8'h40;

   // reset and factory values
   localparam logic [7:0] DEF_CFG  = 8'h1e;
   localparam logic [1:0] DEF_OPC  = 2'h2;
   localparam logic [7:0] DEF_WL   = 8'h00;
   localparam logic [7:0] DEF_MASK = 8'hff;

   // status bit positions
   localparam int STS_CH_FLT_B = 7;
   localparam int STS_VIN_B    = 3;

   // nonvolatile image layout
   localparam int         NV_AW       = 4;
   localparam int         NV_WORDS    = 10;
   localparam logic [3:0] NV_WL_IDX   = 4'h8;
   localparam logic [3:0] NV_MASK_IDX = 4'h9;

   // timing
   localparam int CLK_MHZ     = 25;
   localparam int TICK_US     = 10;
   localparam int TICK_CYC    = TICK_US * CLK_MHZ;
   localparam int INIT_MS     = 135;
   localparam int READBACK_MS = 160;
   localparam int INIT_CYC    = INIT_MS * 1000 * CLK_MHZ;
   localparam int READBACK_CYC = READBACK_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {CH_OFF, CH_WAIT_ON, CH_ON, CH_WAIT_OFF} pops_ch_t;
   typedef enum logic [1:0] {XF_IDLE, XF_STORE, XF_RESTORE} pops_xf_t;

   function automatic logic [7:0] pops_nv_default(input logic [NV_AW-1:0] a);
      if (a == NV_WL_IDX) return DEF_WL;
      if (a == NV_MASK_IDX) return DEF_MASK;
      return DEF_CFG;
   endfunction
endpackage

// ===== hw/pops_store_mem.sv
// pops_store_mem: user nonvolatile image, one byte per word.
// assumes the owner sequences addresses; read data lag one cycle.
`timescale 1ns/100ps
module pops_store_mem
   import pops_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             we,
   input  wire logic [NV_AW-1:0] addr,
   input  wire logic [7:0]       wdata,
   output logic      [7:0]       rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0]            rd;
   } pops_mem_t;

   pops_mem_t s_r;
   pops_mem_t s_nxt;

   initial begin
      if (DEPTH < NV_WORDS || DEPTH > (1 << NV_AW)) $error("pops_store_mem: bad DEPTH");
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rd = s_r.mem[addr];
      if (we) s_nxt.mem[addr] = wdata;
   end

   // factory image loaded at power-on; a real part keeps it across resets
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_r.rd <= 8'h00;
         for (int i = 0; i < DEPTH; i++) s_r.mem[i] <= pops_nv_default(NV_AW'(i));
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rd;
endmodule

// ===== hw/pops_sync.sv
// pops_sync: three-stage input synchroniser for pin levels.
// assumes inputs are asynchronous to clk_sys; output follows once
// stages two and three agree.
`timescale 1ns/100ps
module pops_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pops_sync_t;

   pops_sync_t s_r;
   pops_sync_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = din;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // stage one is never looked at directly
      for (int i = 0; i < W; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) s_nxt.q[i] = s_r.s3[i];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign dout = s_r.q;
endmodule

// ===== tb/pops_pin_model.sv
// pops_pin_model: channel run pins and live fault levels at the far side.
// assumes the bench sets wanted levels just after clock edges.
`timescale 1ns/100ps
module pops_pin_model (
   input  wire logic [7:0] run_req,
   input  wire logic [7:0] flt_req,
   input  wire logic [7:0] lo_req,
   input  wire logic       vin_req,
   input  wire logic       vflt_req,
   output logic      [7:0] channel_run_pin,
   output logic      [7:0] chan_fault,
   output logic            input_voltage_sense,
   output logic            vin_fault,
   output logic      [7:0] chan_latched_off
);
   assign channel_run_pin = run_req;
   assign chan_fault = flt_req;
   // input level, input fault and outside latch-off all follow the bench
   assign input_voltage_sense = vin_req;
   assign vin_fault = vflt_req;
   assign chan_latched_off = lo_req;
endmodule

// ===== tb/tb_pops_ctrl.sv
// tb_pops_ctrl: self-checking bench for the on/off, lock and store block.
// assumes short init counts and one-tick turn-on/off delays.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t value differs", $time); end end
module tb_pops_ctrl;
   import pops_pkg::*;
   logic clk_sys = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, vin_req = 1, vflt_req = 0;
   logic [7:0] cmd_code = 0, cmd_wdata = 0, run_req = 0, flt_req = 0, lo_req = 0, rd;
   logic cmd_ack, cmd_nack, al_o, al_oe, susp, init_done, rb_ok, vs, vf;
   logic [7:0] cmd_rdata, en, pins, cf, lo;
   int fails = 0, n_compared = 0;
   pops_pin_model pm_u (.run_req, .flt_req, .lo_req, .vin_req, .vflt_req,
      .channel_run_pin(pins), .chan_fault(cf), .input_voltage_sense(vs), .vin_fault(vf),
      .chan_latched_off(lo));
   pops_ctrl #(.INIT_CYCLES(20), .RB_CYCLES(30), .TON_TICKS(16'h0001),
      .TOFF_TICKS(16'h0001)) dut_u (.clk_sys, .rst_n, .cmd_valid, .cmd_write,
      .cmd_code, .cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata,
      .channel_run_pin(pins), .input_voltage_sense(vs), .chan_fault(cf),
      .vin_fault(vf), .chan_latched_off(lo), .channel_supply_enable_out(en),
      .shared_alert_output_o(al_o), .shared_alert_output_oe(al_oe),
      .monitor_suspend(susp), .init_done, .readback_valid(rb_ok));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one request; answer taken mid-cycle, while ack or nack stands
   task automatic cmd(input logic w, input logic [7:0] c, d, input logic ok);
      @(posedge clk_sys);
      cmd_valid <= 1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge clk_sys) cmd_valid <= 0;
      @(negedge clk_sys) rd = cmd_rdata;
      `CHK(cmd_ack, ok)
      `CHK(cmd_nack, !ok)
   endtask
   task automatic wait_en(input logic v);
      repeat (600) if (en[0] !== v) @(negedge clk_sys);
      `CHK(en[0], v)
   endtask
   task automatic t_restore();
      cmd(1, CMD_ON_OFF, 8'h00, 0);
      cmd(0, CMD_ON_OFF, 8'h00, 1);
      `CHK(rd, 8'h1e)
      repeat (12) @(negedge clk_sys);
      `CHK({init_done, rb_ok}, 2'b00)
   endtask
   task automatic t_cfg();
      cmd(1, CMD_ON_OFF, 8'hff, 1);
      cmd(0, CMD_ON_OFF, 8'h00, 1);
      `CHK(rd, 8'h1f)
      cmd(1, CMD_PAGE, PAGE_ALL, 1);
      cmd(1, CMD_ON_OFF, 8'h15, 1);
      cmd(1, CMD_PAGE, 8'h03, 1);
      cmd(0, CMD_ON_OFF, 8'h00, 1);
      `CHK(rd, 8'h17)
   endtask
   task automatic t_lock();
      cmd(1, CMD_WRITE_LOCK, WL_L1, 1);
      cmd(1, CMD_OPERATION, 8'h80, 0);
      cmd(1, CMD_PAGE, 8'h00, 1);
      cmd(0, CMD_ON_OFF, 8'h00, 1);
      cmd(1, CMD_WRITE_LOCK, WL_L2, 1);
      cmd(1, CMD_OPERATION, 8'h80, 1);
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      cmd(1, CMD_ON_OFF, 8'h15, 0);
      cmd(1, CMD_WRITE_LOCK, 8'h33, 0);
      cmd(1, CMD_WRITE_LOCK, WL_NONE, 1);
   endtask
   task automatic t_chan();
      repeat (100) if (init_done !== 1'b1) @(negedge clk_sys);
      `CHK(init_done, 1'b1)
      `CHK(en, 8'h00)
      @(posedge clk_sys) run_req <= 8'h01;
      wait_en(1);
      `CHK(en[7:1], 7'h00)
      @(posedge clk_sys) run_req <= 8'h00;
      repeat (8) @(negedge clk_sys);
      `CHK(en[0], 1'b0)
      cmd(1, CMD_ON_OFF, 8'h10, 1);
      @(posedge clk_sys) run_req <= 8'h01;
      repeat (600) @(negedge clk_sys);
      `CHK(en[0], 1'b0)
      // let the synced input level settle low before autonomous mode is set
      @(posedge clk_sys) vin_req <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cmd(1, CMD_ON_OFF, 8'h00, 1);
      repeat (300) @(negedge clk_sys);
      `CHK(en[0], 1'b0)
      @(posedge clk_sys) vin_req <= 1'b1;
      wait_en(1);
      @(posedge clk_sys) lo_req <= 8'h01;
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      repeat (300) @(negedge clk_sys);
      `CHK(en[0], 1'b0)
      @(posedge clk_sys) lo_req <= 8'h00;
      wait_en(1);
      cmd(1, CMD_ON_OFF, 8'h18, 1);
      `CHK(en[0], 1'b1)
      cmd(1, CMD_OPERATION, 8'h00, 1);
      repeat (3) @(negedge clk_sys);
      `CHK(en[0], 1'b0)
      `CHK(rb_ok, 1'b1)
      @(posedge clk_sys) run_req <= 8'h00;
   endtask
   task automatic t_fault();
      @(posedge clk_sys) {vflt_req, flt_req} <= 9'h101;
      @(posedge clk_sys) {vflt_req, flt_req} <= 9'h000;
      repeat (3) @(negedge clk_sys);
      `CHK({al_oe, al_o}, 2'b10)
      cmd(0, CMD_STATUS_IN, 8'h00, 1);
      `CHK(rd[STS_VIN_B], 1'b1)
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      `CHK(al_oe, 1'b0)
      cmd(0, CMD_STATUS_CH, 8'h00, 1);
      `CHK(rd[STS_CH_FLT_B], 1'b0)
      cmd(0, CMD_STATUS_IN, 8'h00, 1);
      `CHK(rd[STS_VIN_B], 1'b0)
      @(posedge clk_sys) flt_req <= 8'h01;
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      cmd(0, CMD_STATUS_CH, 8'h00, 1);
      `CHK(rd[STS_CH_FLT_B], 1'b1)
      @(posedge clk_sys) flt_req <= 8'h00;
      cmd(1, CMD_PAGE, PAGE_ALL, 1);
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      `CHK(al_oe, 1'b1)
      cmd(1, CMD_PAGE, 8'h00, 1);
      cmd(1, CMD_CLEAR_FAULTS, 8'h00, 1);
      `CHK(al_oe, 1'b0)
   endtask
   // channels are off here, as the host should keep them for transfers
   task automatic t_store();
      cmd(1, CMD_STORE_ALL, 8'h00, 1);
      `CHK(susp, 1'b1)
      cmd(1, CMD_ON_OFF, 8'h00, 0);
      repeat (12) @(negedge clk_sys);
      `CHK(susp, 1'b0)
      cmd(1, CMD_ON_OFF, 8'h10, 1);
      cmd(1, CMD_RESTORE_ALL, 8'h00, 1);
      `CHK(susp, 1'b1)
      repeat (13) @(negedge clk_sys);
      `CHK(susp, 1'b0)
      cmd(0, CMD_ON_OFF, 8'h00, 1);
      `CHK(rd, 8'h1a)
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1;
      t_restore();
      t_cfg();
      t_lock();
      t_chan();
      t_fault();
      t_store();
      give_verdict();
   end
   initial begin
      #800000;
      fails++;
      give_verdict();
   end
endmodule
